// File: pkg/lcs_pkg.sv
// constants, encodings and states of the layer compose and scroll block
package lcs_pkg;
  // clock and flash timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SLOW_FLASH_HZ = 2;
  localparam int unsigned FAST_FLASH_HZ = 17;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
  localparam int unsigned LINE_DIV      = 9;
  // command opcodes
  localparam logic [7:0] OP_SYS_SET  = 8'h40;
  localparam logic [7:0] OP_SCROLL   = 8'h44;
  localparam logic [7:0] OP_DISP_OFF = 8'h58;
  localparam logic [7:0] OP_DISP_ON  = 8'h59;
  localparam logic [7:0] OP_SHIFT    = 8'h5A;
  localparam logic [7:0] OP_OVERLAY  = 8'h5B;
  localparam logic [7:0] OP_GRAM_ADR = 8'h5C;
  localparam logic [7:0] OP_CURSOR_SHAPE_COMMAND = 8'h5D;
  // parameter byte indices, first byte is 0
  localparam logic [3:0] PI_0       = 4'h0;
  localparam logic [3:0] PI_1       = 4'h1;
  localparam logic [3:0] PI_2       = 4'h2;
  localparam logic [3:0] PI_3       = 4'h3;
  localparam logic [3:0] PI_4       = 4'h4;
  localparam logic [3:0] PI_5       = 4'h5;
  localparam logic [3:0] PI_6       = 4'h6;
  localparam logic [3:0] PI_7       = 4'h7;
  localparam logic [3:0] PI_LAST    = 4'hF;
  // register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_PARAM  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0C;
  localparam logic [7:0] REG_SAD1   = 8'h10;
  localparam logic [7:0] REG_SAD2   = 8'h14;
  localparam logic [7:0] REG_SAD3   = 8'h18;
  localparam logic [7:0] REG_TIMING = 8'h1C;
  localparam logic [7:0] REG_GRAM   = 8'h20;
  // reset values
  localparam logic [7:0]  TCR_RST   = 8'h2F;
  localparam logic [7:0]  LF_RST    = 8'hC7;
  localparam logic [7:0]  AP_RST    = 8'h28;
  localparam logic [15:0] SAD_RST   = 16'h0000;
  // memory map
  localparam logic [15:0] GLYPH_ROM_BASE = 16'hF000;
  localparam logic [1:0]  GLYPH_RAM_TAG  = 2'h2;
  // field encodings
  localparam logic [1:0] MIX_OR  = 2'h0;
  localparam logic [1:0] MIX_XOR = 2'h1;
  localparam logic [1:0] MIX_AND = 2'h2;
  localparam logic [1:0] FP_OFF  = 2'h0;
  localparam logic [1:0] FP_ON   = 2'h1;
  localparam logic [1:0] FP_SLOW = 2'h2;
  localparam logic [1:0] FP_FAST = 2'h3;
  localparam int OV_B1_GFX = 2;
  localparam int OV_THREE  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {S_IDLE, S_REQ, S_WAIT, S_TAKE, S_EMIT, S_FLUSH} lcs_state_e;
  typedef enum {ST_L1, ST_GLY, ST_L2, ST_L3} lcs_step_e;
endpackage : lcs_pkg

// File: src/lcs_blink.sv
// free running half-period toggle used for flash rates
`timescale 1ns/100ps
module lcs_blink #(
  parameter int unsigned P_HALF = 4
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // phase
  output logic      o_phase
);
  localparam int W = $clog2(P_HALF) + 1;
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      o_phase <= 1'b0;
    end else if (cnt_q == W'(P_HALF - 1)) begin
      cnt_q   <= '0;
      o_phase <= ~o_phase;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule : lcs_blink

// File: src/lcs_core.sv
// layer fetch, mixing, flashing and pixel shift engine with its register slave
`timescale 1ns/100ps
module lcs_core #(
  parameter int unsigned P_SLOW_HALF = lcs_pkg::SLOW_HALF_CYC,
  parameter int unsigned P_FAST_HALF = lcs_pkg::FAST_HALF_CYC
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // axi4-lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // display memory
  output logic [15:0]      o_vram_addr,
  output logic             o_vram_rd,
  input  wire logic [7:0]  i_vram_data,
  // panel
  output logic [7:0]       o_panel_data,
  output logic             o_panel_valid,
  output logic             o_line_start,
  output logic             o_frame_start,
  output logic             o_cursor_vis
);
  // command state and configuration
  logic [7:0]  opcode_q;
  logic [3:0]  pidx_q;
  logic [7:0]  tcr_q;
  logic [7:0]  lf_q;
  logic [7:0]  ap_q;
  logic [15:0] sad1_q;
  logic [15:0] sad2_q;
  logic [15:0] sad3_q;
  logic [7:0]  bl1_q;
  logic [7:0]  bl2_q;
  logic [2:0]  shift_q;
  logic [7:0]  ovl_q;
  logic [7:0]  disp_q;
  logic        disp_on_q;
  logic [7:0]  crx_q;
  logic [7:0]  cry_q;
  logic [15:0] gram_q;
  // bus
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        wr_fire;
  logic        wr_known;
  logic        wr_cmd;
  logic        wr_par;
  logic [31:0] rd_mux;
  logic        rd_known;
  // timing
  logic [11:0] lp_cycles;
  logic [11:0] line_cnt_q;
  logic        line_tick;
  logic        tcr_wr;
  logic [7:0]  line_q;
  logic [15:0] gfx_base_q;
  logic [15:0] txt_base_q;
  logic        slow_ph;
  logic        fast_ph;
  // engine
  lcs_pkg::lcs_state_e state_q;
  lcs_pkg::lcs_step_e  step_q;
  logic [7:0]  col_q;
  logic [3:0]  row_q;
  logic [15:0] lb1_q;
  logic [15:0] lb2_q;
  logic [15:0] lb3_q;
  logic [7:0]  l1_q;
  logic [7:0]  l2_q;
  logic [7:0]  l3_q;
  logic [7:0]  prev_q;
  logic [15:0] req_addr;
  logic        text_mode;
  logic        three_mode;
  logic        code_in_ram;
  logic [7:0]  l1m;
  logic [7:0]  l2m;
  logic [7:0]  l3m;
  logic [7:0]  mixed;
  logic [7:0]  comp;
  logic [15:0] shifted;
  logic [15:0] flushed;

  function automatic logic blk_vis(input logic [1:0] fp, input logic slow, input logic fast);
    case (fp)
      lcs_pkg::FP_ON:   blk_vis = 1'b1;
      lcs_pkg::FP_SLOW: blk_vis = slow;
      lcs_pkg::FP_FAST: blk_vis = fast;
      default:          blk_vis = 1'b0;
    endcase
  endfunction : blk_vis

  lcs_blink #(.P_HALF(P_SLOW_HALF)) u_slow (.i_clock(i_clock), .i_rst_n(i_rst_n), .o_phase(slow_ph));
  lcs_blink #(.P_HALF(P_FAST_HALF)) u_fast (.i_clock(i_clock), .i_rst_n(i_rst_n), .o_phase(fast_ph));

  // write channel: address and data taken in either order, one write at a time
  assign wr_fire  = aw_have_q & w_have_q & ~o_bvalid;
  assign wr_known = (awaddr_q == lcs_pkg::REG_CMD) | (awaddr_q == lcs_pkg::REG_PARAM);
  assign wr_cmd   = wr_fire & wstrb0_q & (awaddr_q == lcs_pkg::REG_CMD);
  assign wr_par   = wr_fire & wstrb0_q & (awaddr_q == lcs_pkg::REG_PARAM);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= lcs_pkg::RESP_OKAY;
    end else begin
      if (o_awready && i_awvalid) begin
        awaddr_q  <= i_awaddr;
        aw_have_q <= 1'b1;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        wdata_q  <= i_wdata;
        wstrb0_q <= i_wstrb[0];
        w_have_q <= 1'b1;
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_known ? lcs_pkg::RESP_OKAY : lcs_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // read mux, unmapped offsets answer slverr with zero data
  always_comb begin
    rd_mux   = '0;
    rd_known = 1'b1;
    case (i_araddr)
      lcs_pkg::REG_CMD:    rd_mux = {20'h00000, pidx_q, opcode_q};
      lcs_pkg::REG_PARAM:  rd_mux = '0;
      lcs_pkg::REG_STATUS: rd_mux = {13'h0000, fast_ph, slow_ph, (state_q != lcs_pkg::S_IDLE), 8'h00, line_q};
      lcs_pkg::REG_CFG:    rd_mux = {cry_q, crx_q, disp_q, ovl_q[4:0], shift_q};
      lcs_pkg::REG_SAD1:   rd_mux = {8'h00, bl1_q, sad1_q};
      lcs_pkg::REG_SAD2:   rd_mux = {8'h00, bl2_q, sad2_q};
      lcs_pkg::REG_SAD3:   rd_mux = {16'h0000, sad3_q};
      lcs_pkg::REG_TIMING: rd_mux = {7'h00, disp_on_q, ap_q, lf_q, tcr_q};
      lcs_pkg::REG_GRAM:   rd_mux = {16'h0000, gram_q};
      default:             rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= lcs_pkg::RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_mux;
      o_rresp   <= rd_known ? lcs_pkg::RESP_OKAY : lcs_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // command and parameter decode; extra parameter bytes are ignored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opcode_q  <= '0;
      pidx_q    <= '0;
      tcr_q     <= lcs_pkg::TCR_RST;
      lf_q      <= lcs_pkg::LF_RST;
      ap_q      <= lcs_pkg::AP_RST;
      sad1_q    <= lcs_pkg::SAD_RST;
      sad2_q    <= lcs_pkg::SAD_RST;
      sad3_q    <= lcs_pkg::SAD_RST;
      bl1_q     <= lcs_pkg::LF_RST;
      bl2_q     <= lcs_pkg::LF_RST;
      shift_q   <= '0;
      ovl_q     <= '0;
      disp_q    <= '0;
      disp_on_q <= 1'b0;
      crx_q     <= '0;
      cry_q     <= '0;
      gram_q    <= '0;
    end else if (wr_cmd) begin
      opcode_q <= wdata_q[7:0];
      pidx_q   <= lcs_pkg::PI_0;
      if (wdata_q[7:0] == lcs_pkg::OP_DISP_ON || wdata_q[7:0] == lcs_pkg::OP_DISP_OFF) begin
        disp_on_q <= (wdata_q[7:0] == lcs_pkg::OP_DISP_ON);
      end
    end else if (wr_par) begin
      if (pidx_q != lcs_pkg::PI_LAST) begin
        pidx_q <= pidx_q + 4'h1;
      end
      case (opcode_q)
        lcs_pkg::OP_SYS_SET: begin
          if (pidx_q == lcs_pkg::PI_4) tcr_q <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_5) lf_q <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_6) ap_q <= wdata_q[7:0];
        end
        lcs_pkg::OP_SCROLL: begin
          if (pidx_q == lcs_pkg::PI_0) sad1_q[7:0] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_1) sad1_q[15:8] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_2) bl1_q <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_3) sad2_q[7:0] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_4) sad2_q[15:8] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_5) bl2_q <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_6) sad3_q[7:0] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_7) sad3_q[15:8] <= wdata_q[7:0];
        end
        lcs_pkg::OP_SHIFT: if (pidx_q == lcs_pkg::PI_0) shift_q <= wdata_q[2:0];
        lcs_pkg::OP_OVERLAY: if (pidx_q == lcs_pkg::PI_0) ovl_q <= wdata_q[7:0];
        lcs_pkg::OP_DISP_ON, lcs_pkg::OP_DISP_OFF: begin
          if (pidx_q == lcs_pkg::PI_0) disp_q <= wdata_q[7:0];
        end
        lcs_pkg::OP_CURSOR_SHAPE_COMMAND: begin
          if (pidx_q == lcs_pkg::PI_0) crx_q <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_1) cry_q <= wdata_q[7:0];
        end
        lcs_pkg::OP_GRAM_ADR: begin
          if (pidx_q == lcs_pkg::PI_0) gram_q[7:0] <= wdata_q[7:0];
          if (pidx_q == lcs_pkg::PI_1) gram_q[15:8] <= wdata_q[7:0];
        end
        default: ;
      endcase
    end
  end

  // line and frame timing: line lasts 9 x (field + 1) clocks
  assign lp_cycles = 12'(lcs_pkg::LINE_DIV) * ({4'h0, tcr_q} + 12'h001);
  assign line_tick = (line_cnt_q >= lp_cycles - 12'h001);
  assign tcr_wr    = wr_par && opcode_q == lcs_pkg::OP_SYS_SET && pidx_q == lcs_pkg::PI_4;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_cnt_q    <= '0;
      line_q        <= '0;
      gfx_base_q    <= '0;
      txt_base_q    <= '0;
      o_line_start  <= 1'b0;
      o_frame_start <= 1'b0;
    end else begin
      o_line_start  <= line_tick;
      o_frame_start <= line_tick && (line_q >= lf_q);
      // a new line field restarts the line so the count never runs past its end
      line_cnt_q    <= (line_tick || tcr_wr) ? 12'h000 : line_cnt_q + 12'h001;
      if (line_tick && line_q >= lf_q) begin
        line_q     <= '0;
        gfx_base_q <= '0;
        txt_base_q <= '0;
      end else if (line_tick) begin
        line_q     <= line_q + 8'h01;
        gfx_base_q <= gfx_base_q + {8'h00, ap_q};
        if (&line_q[2:0]) begin
          txt_base_q <= txt_base_q + {8'h00, ap_q};
        end
      end
    end
  end

  // fetch address selection over the 64KB space
  assign text_mode   = ~ovl_q[lcs_pkg::OV_B1_GFX];
  assign three_mode  = ovl_q[lcs_pkg::OV_THREE];
  assign code_in_ram = (l1_q[7:6] == lcs_pkg::GLYPH_RAM_TAG);

  always_comb begin
    req_addr = lb1_q + {8'h00, col_q};
    case (step_q)
      lcs_pkg::ST_GLY: begin
        if (code_in_ram) req_addr = gram_q + {6'h00, l1_q[5:0], row_q};
        else req_addr = lcs_pkg::GLYPH_ROM_BASE + {4'h0, l1_q, row_q};
      end
      lcs_pkg::ST_L2: req_addr = lb2_q + {8'h00, col_q};
      lcs_pkg::ST_L3: req_addr = lb3_q + {8'h00, col_q};
      default: ;
    endcase
  end

  // block visibility, mixing and whole-picture shift
  assign l1m = blk_vis(disp_q[3:2], slow_ph, fast_ph) ? l1_q : 8'h00;
  assign l2m = blk_vis(disp_q[5:4], slow_ph, fast_ph) ? l2_q : 8'h00;
  assign l3m = (three_mode && blk_vis(disp_q[7:6], slow_ph, fast_ph)) ? l3_q : 8'h00;

  always_comb begin
    case (ovl_q[1:0])
      lcs_pkg::MIX_XOR: mixed = l1m ^ l2m;
      lcs_pkg::MIX_AND: mixed = l1m & l2m;
      default:          mixed = l1m | l2m;
    endcase
  end

  assign comp    = mixed | l3m;
  assign shifted = {prev_q, comp} << shift_q;
  assign flushed = {prev_q, 8'h00} << shift_q;

  // one column per pass; a line tick that finds the engine busy is dropped
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q       <= lcs_pkg::S_IDLE;
      step_q        <= lcs_pkg::ST_L1;
      col_q         <= '0;
      row_q         <= '0;
      lb1_q         <= '0;
      lb2_q         <= '0;
      lb3_q         <= '0;
      l1_q          <= '0;
      l2_q          <= '0;
      l3_q          <= '0;
      prev_q        <= '0;
      o_vram_addr   <= '0;
      o_vram_rd     <= 1'b0;
      o_panel_data  <= '0;
      o_panel_valid <= 1'b0;
      o_cursor_vis  <= 1'b0;
    end else begin
      o_panel_valid <= 1'b0;
      o_cursor_vis  <= disp_on_q & blk_vis(disp_q[1:0], slow_ph, fast_ph);
      case (state_q)
        lcs_pkg::S_IDLE: begin
          if (o_line_start && disp_on_q && ap_q != 8'h00) begin
            col_q   <= '0;
            prev_q  <= '0;
            row_q   <= {1'b0, line_q[2:0]};
            lb1_q   <= sad1_q + (text_mode ? txt_base_q : gfx_base_q);
            lb2_q   <= sad2_q + gfx_base_q;
            lb3_q   <= sad3_q + gfx_base_q;
            step_q  <= lcs_pkg::ST_L1;
            state_q <= lcs_pkg::S_REQ;
          end
        end
        lcs_pkg::S_REQ: begin
          o_vram_addr <= req_addr;
          o_vram_rd   <= 1'b1;
          state_q     <= lcs_pkg::S_WAIT;
        end
        lcs_pkg::S_WAIT: begin
          o_vram_rd <= 1'b0;
          state_q   <= lcs_pkg::S_TAKE;
        end
        lcs_pkg::S_TAKE: begin
          state_q <= lcs_pkg::S_REQ;
          case (step_q)
            lcs_pkg::ST_L1: begin
              l1_q   <= i_vram_data;
              step_q <= text_mode ? lcs_pkg::ST_GLY : lcs_pkg::ST_L2;
            end
            lcs_pkg::ST_GLY: begin
              l1_q   <= i_vram_data;
              step_q <= lcs_pkg::ST_L2;
            end
            lcs_pkg::ST_L2: begin
              l2_q <= i_vram_data;
              if (three_mode) step_q <= lcs_pkg::ST_L3;
              else state_q <= lcs_pkg::S_EMIT;
            end
            default: begin
              l3_q    <= i_vram_data;
              state_q <= lcs_pkg::S_EMIT;
            end
          endcase
        end
        lcs_pkg::S_EMIT: begin
          o_panel_valid <= (col_q != 8'h00);
          o_panel_data  <= shifted[15:8];
          prev_q        <= comp;
          step_q        <= lcs_pkg::ST_L1;
          if (col_q == ap_q - 8'h01) begin
            state_q <= lcs_pkg::S_FLUSH;
          end else begin
            col_q   <= col_q + 8'h01;
            state_q <= lcs_pkg::S_REQ;
          end
        end
        lcs_pkg::S_FLUSH: begin
          o_panel_valid <= 1'b1;
          o_panel_data  <= flushed[15:8];
          state_q       <= lcs_pkg::S_IDLE;
        end
        default: state_q <= lcs_pkg::S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_fetch;
    state_q == lcs_pkg::S_WAIT ##1 state_q == lcs_pkg::S_TAKE;
  endsequence
  property p_fetch_seq;
    state_q == lcs_pkg::S_REQ |=> s_fetch;
  endproperty
  a_fetch_seq: assert property (p_fetch_seq) else $error("fetch did not wait then take");

  property p_line_period;
    line_tick |-> line_cnt_q == lp_cycles - 12'h001;
  endproperty
  a_line_period: assert property (p_line_period) else $error("line period count wrong");

  property p_rom_addr;
    state_q == lcs_pkg::S_REQ && step_q == lcs_pkg::ST_GLY && !code_in_ram
      |=> o_vram_addr[15:12] == lcs_pkg::GLYPH_ROM_BASE[15:12] && o_vram_rd;
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("glyph rom fetch outside its range");

  property p_ram_addr;
    state_q == lcs_pkg::S_REQ && step_q == lcs_pkg::ST_GLY && code_in_ram
      |=> o_vram_addr == $past(gram_q) + {6'h00, $past(l1_q[5:0]), $past(row_q)};
  endproperty
  a_ram_addr: assert property (p_ram_addr) else $error("glyph ram address wrong");

  property p_layer2_addr;
    state_q == lcs_pkg::S_REQ && step_q == lcs_pkg::ST_L2 |=> o_vram_addr == $past(lb2_q) + {8'h00, $past(col_q)};
  endproperty
  a_layer2_addr: assert property (p_layer2_addr) else $error("graphics byte address wrong");

  property p_xor_mix;
    state_q == lcs_pkg::S_EMIT && ovl_q[1:0] == lcs_pkg::MIX_XOR && !three_mode |-> comp == (l1m ^ l2m);
  endproperty
  a_xor_mix: assert property (p_xor_mix) else $error("xor mix not applied");

  property p_fast_flash;
    state_q == lcs_pkg::S_EMIT && disp_q[5:4] == lcs_pkg::FP_FAST && !fast_ph |-> l2m == 8'h00;
  endproperty
  a_fast_flash: assert property (p_fast_flash) else $error("fast flash block shown in off phase");

  property p_slow_flash;
    state_q == lcs_pkg::S_EMIT && disp_q[5:4] == lcs_pkg::FP_SLOW && slow_ph |-> l2m == l2_q;
  endproperty
  a_slow_flash: assert property (p_slow_flash) else $error("slow flash block hidden in on phase");

  property p_shift_out;
    state_q == lcs_pkg::S_EMIT && col_q != 8'h00
      |=> o_panel_valid && o_panel_data == 8'(({$past(prev_q), $past(comp)} << $past(shift_q)) >> 8);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("shifted panel byte wrong");

  property p_scroll_lo;
    wr_par && opcode_q == lcs_pkg::OP_SCROLL && pidx_q == lcs_pkg::PI_0 |=> sad1_q[7:0] == $past(wdata_q[7:0]);
  endproperty
  a_scroll_lo: assert property (p_scroll_lo) else $error("start address low byte not stored");
endmodule : lcs_core

// File: verif/lcs_vram_model.sv
// display memory model answering each fetch one cycle after its read pulse
`timescale 1ns/100ps
module lcs_vram_model (
  // clock
  input  wire logic        i_clock,
  // fetch request
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  // fetched byte
  output logic      [7:0]  o_data
);
  initial o_data = 8'h00;
  // idle bus flips every cycle so a late sample never matches by luck
  always @(posedge i_clock) begin
    if (i_rd) begin
      o_data <= (i_addr[15:8] * 8'h03) ^ i_addr[7:0];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule : lcs_vram_model

// File: verif/tb_top.sv
// self-checking bench for the layer compose and scroll core
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, vrd, pv, ls, fs, cv;
  logic [7:0]  awaddr, araddr, vdata, pdata;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] vaddr;
  int          failures, n_compared;

  // half periods chosen so both blink phases flip between frames of 72 clocks
  lcs_core #(.P_SLOW_HALF(24), .P_FAST_HALF(8)) i_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_vram_addr(vaddr), .o_vram_rd(vrd), .i_vram_data(vdata), .o_panel_data(pdata),
    .o_panel_valid(pv), .o_line_start(ls), .o_frame_start(fs), .o_cursor_vis(cv));
  lcs_vram_model i_mem (.i_clock(clk), .i_addr(vaddr), .i_rd(vrd), .o_data(vdata));

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 400) begin
      failures++;
      $display("ERROR %0t: wait timed out", $time);
      test_done();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      tick(n);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      tick(n);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic cmd(input logic [7:0] op, input logic [7:0] p[$]);
    wr(lcs_pkg::REG_CMD, {24'h0, op}, lcs_pkg::RESP_OKAY);
    foreach (p[i]) wr(lcs_pkg::REG_PARAM, {24'h0, p[i]}, lcs_pkg::RESP_OKAY);
  endtask : cmd

  task automatic t_regs();
    rd(lcs_pkg::REG_TIMING, 32'h0028C72F, lcs_pkg::RESP_OKAY);
    rd(lcs_pkg::REG_CFG, 32'h0, lcs_pkg::RESP_OKAY);
    rd(8'h24, 32'h0, lcs_pkg::RESP_SLVERR);
    wr(lcs_pkg::REG_STATUS, 32'h1, lcs_pkg::RESP_SLVERR);
  endtask : t_regs

  // short line and frame keep each mix case to a few hundred cycles
  task automatic t_setup();
    cmd(lcs_pkg::OP_SYS_SET, '{8'h30, 8'h87, 8'h07, 8'h27, 8'h03, 8'h01, 8'h02, 8'h00});
    rd(lcs_pkg::REG_TIMING, 32'h00020103, lcs_pkg::RESP_OKAY);
    cmd(lcs_pkg::OP_SCROLL, '{8'h00, 8'h01, 8'h02, 8'h00, 8'h02, 8'h02});
    rd(lcs_pkg::REG_SAD1, 32'h00020100, lcs_pkg::RESP_OKAY);
    rd(lcs_pkg::REG_SAD2, 32'h00020200, lcs_pkg::RESP_OKAY);
    cmd(lcs_pkg::OP_CURSOR_SHAPE_COMMAND, '{8'h04, 8'h86});
  endtask : t_setup

  task automatic t_mix(input logic [1:0] mx, input logic [2:0] sh, input logic [7:0] ex);
    int         n;
    int         cyc;
    logic [7:0] got;
    n = 0;
    cyc = 0;
    got = 8'h00;
    cmd(lcs_pkg::OP_SHIFT, '{{5'h00, sh}});
    cmd(lcs_pkg::OP_OVERLAY, '{{6'h03, mx}});
    cmd(lcs_pkg::OP_DISP_ON, '{8'h14});
    rd(lcs_pkg::REG_CFG, {24'h860414, 3'h3, mx, sh}, lcs_pkg::RESP_OKAY);
    do tick(n); while (fs !== 1'b1);
    do begin
      tick(n);
      cyc++;
      if (pv === 1'b1 && got === 8'h00) got = pdata;
    end while (ls !== 1'b1);
    chk({24'h0, got}, {24'h0, ex});
    chk(cyc, 36);
  endtask : t_mix

  // layer 2 flashes; a frame of 72 clocks flips each blink phase between frames
  task automatic t_flash(input logic [7:0] ov, en, ex_x, ex_o);
    int         n;
    logic [7:0] got[2];
    n = 0;
    cmd(lcs_pkg::OP_SHIFT, '{8'h00});
    cmd(lcs_pkg::OP_OVERLAY, '{ov});
    cmd(lcs_pkg::OP_DISP_ON, '{en});
    for (int f = 0; f < 2; f++) begin
      do tick(n); while (fs !== 1'b1);
      do tick(n); while (pv !== 1'b1);
      got[f] = pdata;
    end
    chk({24'h0, got[0] ^ got[1]}, {24'h0, ex_x});
    chk({24'h0, got[0] | got[1]}, {24'h0, ex_o});
    chk({31'h0, cv}, {31'h0, en[1:0] == lcs_pkg::FP_ON});
  endtask : t_flash

  // smooth scroll: one pixel a step, then shift back to zero and start one byte on
  task automatic t_scroll();
    logic [7:0] ex[7];
    ex = '{8'h0E, 8'h1C, 8'h38, 8'h70, 8'hE0, 8'hC1, 8'h83};
    for (int k = 1; k < 8; k++) t_mix(2'h0, 3'(k), ex[k-1]);
    cmd(lcs_pkg::OP_SCROLL, '{8'h01, 8'h01, 8'h02, 8'h00, 8'h02, 8'h02});
    rd(lcs_pkg::REG_SAD1, 32'h00020101, lcs_pkg::RESP_OKAY);
    // one byte of travel equals eight pixel steps, so the shift goes back to zero here
    t_mix(2'h0, 3'h0, 8'h06);
  endtask : t_scroll

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    failures = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_setup();
    t_mix(2'h1, 3'h0, 8'h05);
    t_mix(2'h0, 3'h0, 8'h07);
    t_mix(2'h2, 3'h0, 8'h02);
    t_mix(2'h3, 3'h0, 8'h07);
    t_mix(2'h0, 3'h3, 8'h38);
    t_flash(8'h0C, 8'h25, 8'h04, 8'h07);
    t_flash(8'h00, 8'h34, 8'h06, 8'hE6);
    t_scroll();
    cmd(lcs_pkg::OP_DISP_OFF, '{8'h00});
    rd(lcs_pkg::REG_TIMING, 32'h00020103, lcs_pkg::RESP_OKAY);
    test_done();
  end
endmodule : tb_top
